// ---- rtl/ccp_pkg.sv ----
// package: register map, field layout, mode codes and carriers of the capture/compare/pwm unit
package ccp_pkg;

  // ==========================================================================
  // register map: printed offsets are word indices, byte address is four times
  // ==========================================================================
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  IDX_VALUE_LOW  = 8'h15;
  localparam logic [7:0]  IDX_VALUE_HIGH = 8'h16;
  localparam logic [7:0]  IDX_CONTROL    = 8'h17;
  localparam logic [7:0]  IDX_STATUS     = 8'h18;
  localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'h19;
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'h1a;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 4;
  localparam int          DUTY_LSB_POS   = 4;
  localparam int          CTRL_USED_W    = 6;
  localparam int          FLAG_BIT       = 0;
  localparam int          DUTY_W         = 10;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  VALUE_RST      = 8'h00;
  localparam logic        STATUS_RST     = 1'b0;
  localparam logic        ENABLE_RST     = 1'b0;

  // ==========================================================================
  // mode select encodings
  // ==========================================================================
  localparam logic [3:0]  MODE_OFF       = 4'h0;
  localparam logic [3:0]  MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0]  MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0]  MODE_CAP_4     = 4'h6;
  localparam logic [3:0]  MODE_CAP_16    = 4'h7;
  localparam logic [3:0]  MODE_CMP_SET   = 4'h8;
  localparam logic [3:0]  MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0]  MODE_CMP_SOFT  = 4'ha;
  localparam logic [3:0]  MODE_CMP_SPEC  = 4'hb;

  // last count of the edge prescaler before an event
  localparam logic [3:0]  PRE_4_LAST     = 4'h3;
  localparam logic [3:0]  PRE_16_LAST    = 4'hf;
  localparam logic [3:0]  PRE_RST        = 4'h0;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ccp_apb_req_s;

  typedef struct packed {
    logic [15:0] t1_count;
    logic [7:0]  t2_count;
    logic [7:0]  t2_period;
    logic        t2_inc;
    logic [1:0]  t2_fine;
  } ccp_timer_s;

  // ==========================================================================
  // decoding shared by several processes
  // ==========================================================================
  function automatic logic [ADDR_W-1:0] idx_to_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  function automatic logic mode_is_capture(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction

  function automatic logic mode_is_compare(input logic [3:0] m);
    return m[3:2] == 2'b10;
  endfunction

  function automatic logic mode_is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction

endpackage

// ---- rtl/ccp_prescale.sv ----
// edge prescaler of the capture path
`timescale 1ns/100ps
module ccp_prescale
  import ccp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] mode,
  input  wire logic       rise,
  input  wire logic       fall,
  output logic            event_hit
);

  logic [3:0] count_ff;
  logic       last_hit;

  always_comb begin
    last_hit = 1'b0;
    case (mode)
      MODE_CAP_4:  last_hit = count_ff[1:0] == PRE_4_LAST[1:0];
      MODE_CAP_16: last_hit = count_ff == PRE_16_LAST;
      default:     last_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // event select
  // ==========================================================================
  always_comb begin
    case (mode)
      MODE_CAP_FALL: event_hit = fall;
      MODE_CAP_RISE: event_hit = rise;
      MODE_CAP_4,
      MODE_CAP_16:   event_hit = rise & last_hit;
      default:       event_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // counter: held at zero outside capture, kept across prescaler changes
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= PRE_RST;
    end else if (!mode_is_capture(mode)) begin
      count_ff <= PRE_RST;
    end else if (rise && (mode == MODE_CAP_4 || mode == MODE_CAP_16)) begin
      // no clear on a prescaler change, so the next event may come early
      count_ff <= last_hit ? PRE_RST : count_ff + 4'h1;
    end
  end

endmodule

// ---- rtl/ccp_unit_top.sv ----
// capture/compare/pwm unit with apb register slave and interrupt
`timescale 1ns/100ps
// Operation
// - four capture prescaler choices come from the mode select field
// - prescaler counter held at zero when off or not in capture
// - any reset clears the prescaler counter
// - switching prescalers keeps the count, first capture may come early
// - compare mode sets the flag whenever value equals timer one
// - on match the pin goes high, low or stays, per mode select
// - writing zero to control forces the compare output latch low
// - software interrupt compare mode only raises the flag, pin untouched
// - special event match resets timer one through a trigger pulse
// - pwm mode drives the pin with a duty of up to ten bits
// - writing zero to control forces the pwm output latch low
// - mode codes for off and the four capture edge choices
// - mode codes for the four compare actions and pwm
// - capture copies timer one into the value register and sets the flag
// - pwm period end clears timer two, sets pin if the buffered duty is nonzero, reloads high byte
module ccp_unit_top
  import ccp_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire ccp_pkg::ccp_apb_req_s apb_req,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire ccp_pkg::ccp_timer_s timer_in,
  input  wire logic                unit_pin_in,
  output logic                     unit_output_pin,
  output logic                     timer_one_reset,
  output logic                     timer_two_clear,
  output logic                     irq
);

  import ccp_pkg::*;

  // ==========
  // state
  // ==========
  logic [7:0]        ccp_value_low_ff;
  logic [7:0]        ccp_value_high_ff;
  logic [7:0]        ccp_control_ff;
  logic [1:0]        duty_latch_ff;
  logic              capcomp_flag_ff;
  logic              capcomp_irq_enable_ff;
  logic              pin_ff;
  logic              timer_one_reset_ff;
  logic              timer_two_clear_ff;
  logic              irq_ff;
  logic              pin_meta_ff;
  logic              pin_sync_ff;
  logic              pin_prev_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  // ==========
  // decode
  // ==========
  logic [3:0]        mode;
  logic              setup_phase;
  logic              wr_commit;
  logic              addr_known;
  logic              wr_low;
  logic              wr_high;
  logic              wr_ctrl;
  logic              wr_clear;
  logic              wr_enable;
  logic              ctrl_zeroed;
  logic              pin_rise;
  logic              pin_fall;
  logic              capture_hit;
  logic              compare_hit;
  logic              period_end;
  logic              duty_end;
  logic [DUTY_W-1:0] duty_buffered;
  logic [DUTY_W-1:0] duty_active;
  logic [DUTY_W-1:0] pwm_position;
  logic [31:0]       nxt_prdata;

  assign mode        = ccp_control_ff[MODE_LSB +: MODE_W];
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  // pready is only high in the access cycle, so this marks the one commit edge
  assign wr_commit   = apb_req.psel & apb_req.penable & pready_ff & apb_req.pwrite;
  assign wr_low      = wr_commit && apb_req.paddr == idx_to_addr(IDX_VALUE_LOW);
  assign wr_high     = wr_commit && apb_req.paddr == idx_to_addr(IDX_VALUE_HIGH);
  assign wr_ctrl     = wr_commit && apb_req.paddr == idx_to_addr(IDX_CONTROL);
  assign wr_clear    = wr_commit && apb_req.paddr == idx_to_addr(IDX_IRQ_CLEAR);
  assign wr_enable   = wr_commit && apb_req.paddr == idx_to_addr(IDX_IRQ_ENABLE);
  assign ctrl_zeroed = wr_ctrl && apb_req.pwdata[7:0] == CTRL_RST;

  always_comb begin
    case (apb_req.paddr)
      idx_to_addr(IDX_VALUE_LOW),
      idx_to_addr(IDX_VALUE_HIGH),
      idx_to_addr(IDX_CONTROL),
      idx_to_addr(IDX_STATUS),
      idx_to_addr(IDX_IRQ_CLEAR),
      idx_to_addr(IDX_IRQ_ENABLE): addr_known = 1'b1;
      default:                     addr_known = 1'b0;
    endcase
  end

  // ==========
  // pin synchroniser and edge detect
  // ==========
  // only pin_sync_ff and later stages feed logic; a port write looped back
  // to the pin counts as an edge, which is how the pin itself behaves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= unit_pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  assign pin_rise = pin_sync_ff & ~pin_prev_ff;
  assign pin_fall = ~pin_sync_ff & pin_prev_ff;

  // ==========
  // capture path
  // ==========
  ccp_prescale u_prescale (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (mode),
    .rise      (pin_rise),
    .fall      (pin_fall),
    .event_hit (capture_hit)
  );

  // ==========
  // compare and pwm matching
  // ==========
  // equality every cycle, so a timer that stalls on the match keeps setting
  // the flag; a synchronous timer one is assumed
  assign compare_hit   = mode_is_compare(mode) && timer_in.t1_count ==
                         {ccp_value_high_ff, ccp_value_low_ff};
  assign duty_buffered = {ccp_value_low_ff, ccp_control_ff[DUTY_LSB_POS +: 2]};
  assign duty_active   = {ccp_value_high_ff, duty_latch_ff};
  assign pwm_position  = {timer_in.t2_count, timer_in.t2_fine};
  assign period_end    = mode_is_pwm(mode) && timer_in.t2_inc &&
                         timer_in.t2_count == timer_in.t2_period;
  // cleared at the last high step, so the pin stays high for duty steps
  assign duty_end      = mode_is_pwm(mode) && duty_active == pwm_position + DUTY_W'(1);

  // ==========
  // value register
  // ==========
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccp_value_low_ff <= VALUE_RST;
    end else if (capture_hit) begin
      // a capture overwrites even an unread value, and wins over a write
      ccp_value_low_ff <= timer_in.t1_count[7:0];
    end else if (wr_low) begin
      ccp_value_low_ff <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccp_value_high_ff <= VALUE_RST;
    end else if (capture_hit) begin
      ccp_value_high_ff <= timer_in.t1_count[15:8];
    end else if (period_end) begin
      ccp_value_high_ff <= ccp_value_low_ff;
    end else if (wr_high && !mode_is_pwm(mode)) begin
      // read-only while pwm uses it as the active duty
      ccp_value_high_ff <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_latch_ff <= 2'b00;
    end else if (period_end) begin
      duty_latch_ff <= ccp_control_ff[DUTY_LSB_POS +: 2];
    end
  end

  // ==========
  // control register
  // ==========
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccp_control_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      // software is expected to pass through off when changing prescaler
      ccp_control_ff <= {2'b00, apb_req.pwdata[CTRL_USED_W-1:0]};
    end
  end

  // ==========
  // flag, enable, interrupt
  // ==========
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capcomp_flag_ff <= STATUS_RST;
    end else if (capture_hit || compare_hit) begin
      // set wins over a clear in the same cycle; mode changes may set it
      capcomp_flag_ff <= 1'b1;
    end else if (wr_clear && apb_req.pwdata[FLAG_BIT]) begin
      capcomp_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capcomp_irq_enable_ff <= ENABLE_RST;
    end else if (wr_enable) begin
      capcomp_irq_enable_ff <= apb_req.pwdata[FLAG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= capcomp_flag_ff & capcomp_irq_enable_ff;
    end
  end

  // ==========
  // output latch
  // ==========
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= 1'b0;
    end else if (ctrl_zeroed) begin
      pin_ff <= 1'b0;
    end else if (compare_hit) begin
      case (mode)
        MODE_CMP_SET: pin_ff <= 1'b1;
        MODE_CMP_CLR: pin_ff <= 1'b0;
        default:      pin_ff <= pin_ff;
      endcase
    end else if (period_end) begin
      pin_ff <= duty_buffered != '0;
    end else if (duty_end) begin
      // a duty longer than the period never reaches this and leaves it high
      pin_ff <= 1'b0;
    end else if (mode == MODE_OFF) begin
      pin_ff <= 1'b0;
    end
  end

  // ==========
  // timer trigger pulses
  // ==========
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_one_reset_ff <= 1'b0;
    end else begin
      timer_one_reset_ff <= compare_hit && mode == MODE_CMP_SPEC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_two_clear_ff <= 1'b0;
    end else begin
      timer_two_clear_ff <= period_end;
    end
  end

  // ==========
  // apb slave: no wait state, answer in the first access cycle
  // ==========
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (apb_req.paddr)
      idx_to_addr(IDX_VALUE_LOW):  nxt_prdata[7:0] = ccp_value_low_ff;
      idx_to_addr(IDX_VALUE_HIGH): nxt_prdata[7:0] = ccp_value_high_ff;
      idx_to_addr(IDX_CONTROL):    nxt_prdata[7:0] = ccp_control_ff;
      idx_to_addr(IDX_STATUS):     nxt_prdata[FLAG_BIT] = capcomp_flag_ff;
      idx_to_addr(IDX_IRQ_ENABLE): nxt_prdata[FLAG_BIT] = capcomp_irq_enable_ff;
      default:                     nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup_phase;
      pslverr_ff <= setup_phase & ~addr_known;
      if (setup_phase && !apb_req.pwrite) begin
        prdata_ff <= nxt_prdata;
      end else if (!apb_req.psel) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========
  // outputs
  // ==========
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign unit_output_pin = pin_ff;
  assign timer_one_reset = timer_one_reset_ff;
  assign timer_two_clear = timer_two_clear_ff;
  assign irq             = irq_ff;

endmodule

// ---- test/ccp_unit_sva.sv ----
// port checker of the capture/compare/pwm unit, with its bind
`timescale 1ns/100ps
module ccp_unit_sva (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire ccp_pkg::ccp_apb_req_s apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire ccp_pkg::ccp_timer_s   timer_in,
  input wire logic                  unit_pin_in,
  input wire logic                  unit_output_pin,
  input wire logic                  timer_one_reset,
  input wire logic                  timer_two_clear,
  input wire logic                  irq
);
  import ccp_pkg::*;
  // ==========================================================================
  // shadow of control and value, kept from committed writes
  // ==========================================================================
  localparam logic [7:0] A_LOW  = {IDX_VALUE_LOW[5:0], 2'b00};
  localparam logic [7:0] A_HIGH = {IDX_VALUE_HIGH[5:0], 2'b00};
  logic [5:0]  ctrl_ff;
  logic [15:0] val_ff;
  logic        val_ok_ff;
  logic        wr;
  logic        ctrl_wr;
  logic        hit;
  logic        mapped;
  assign wr      = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  assign ctrl_wr = wr && apb_req.paddr == {IDX_CONTROL[5:0], 2'b00};
  assign mapped  = apb_req.paddr inside {8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};
  assign hit     = val_ok_ff && ctrl_ff[3:2] == 2'b10 && timer_in.t1_count == val_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_ff <= 6'h00;
    else if (ctrl_wr) ctrl_ff <= apb_req.pwdata[5:0];
  end
  // value is trusted only once rewritten in compare mode: captures and
  // pwm reloads change it where this shadow cannot see
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_ff    <= 16'h0000;
      val_ok_ff <= 1'b0;
    end else begin
      if (wr && apb_req.paddr == A_LOW) val_ff[7:0] <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr == A_HIGH) val_ff[15:8] <= apb_req.pwdata[7:0];
      if (ctrl_wr && apb_req.pwdata[3:2] != 2'b10) val_ok_ff <= 1'b0;
      else if (wr && apb_req.paddr == A_HIGH && ctrl_ff[3:2] == 2'b10) val_ok_ff <= 1'b1;
    end
  end
  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> pready)
    else $error("no answer in the access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_cmp_set_pin: assert property (hit && ctrl_ff[3:0] == MODE_CMP_SET && !ctrl_wr |=> unit_output_pin)
    else $error("pin not set on match");
  a_cmp_clr_pin: assert property (hit && ctrl_ff[3:0] == MODE_CMP_CLR && !ctrl_wr |=> !unit_output_pin)
    else $error("pin not cleared on match");
  a_soft_pin_hold: assert property (ctrl_ff[3:0] == MODE_CMP_SOFT && !ctrl_wr |=> $stable(unit_output_pin))
    else $error("pin moved in flag only mode");
  a_spec_event_fire: assert property (hit && ctrl_ff[3:0] == MODE_CMP_SPEC |=> timer_one_reset)
    else $error("no trigger on match");
  a_zero_ctrl_low: assert property (ctrl_ff == 6'h00 |-> !unit_output_pin)
    else $error("pin high with control zero");
  a_pwm_period_end: assert property (ctrl_ff[3:2] == 2'b11 && timer_in.t2_inc
      && timer_in.t2_count == timer_in.t2_period |=> timer_two_clear)
    else $error("no period end pulse");
  c_spec: cover property (hit && ctrl_ff[3:0] == MODE_CMP_SPEC);
  c_period: cover property (timer_two_clear);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule

bind ccp_unit_top ccp_unit_sva u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
  .unit_pin_in(unit_pin_in), .unit_output_pin(unit_output_pin),
  .timer_one_reset(timer_one_reset), .timer_two_clear(timer_two_clear), .irq(irq));

// ---- test/ccp_partner.sv ----
// timer one and timer two sources standing outside the unit
`timescale 1ns/100ps
module ccp_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        t1_hold,
  input  wire logic [15:0] t1_val,
  input  wire logic        t1_reset_req,
  input  wire logic [7:0]  t2_period,
  input  wire logic        t2_clear_req,
  output ccp_pkg::ccp_timer_s timer_out
);
  import ccp_pkg::*;
  logic [15:0] t1_ff;
  logic [7:0]  t2_ff;
  logic [1:0]  fine_ff;
  // timer one runs on pclk only, so the unit sees it synchronously
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t1_ff <= 16'h0000;
    else if (t1_reset_req) t1_ff <= 16'h0000;
    else if (t1_hold) t1_ff <= t1_val;
    else t1_ff <= t1_ff + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fine_ff <= 2'b00;
    else fine_ff <= fine_ff + 2'b01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t2_ff <= 8'h00;
    else if (t2_clear_req) t2_ff <= 8'h00;
    else if (fine_ff == 2'b11) t2_ff <= (t2_ff == t2_period) ? 8'h00 : t2_ff + 8'h01;
  end
  assign timer_out = '{t1_count: t1_ff, t2_count: t2_ff, t2_period: t2_period,
                       t2_inc: fine_ff == 2'b11, t2_fine: fine_ff};
endmodule

// ---- test/ccp_unit_top_bench.sv ----
// self-checking bench of the capture/compare/pwm unit
`timescale 1ns/100ps
module ccp_unit_top_bench;
  import ccp_pkg::*;
  logic                 pclk;
  logic                 presetn;
  ccp_pkg::ccp_apb_req_s req;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  ccp_pkg::ccp_timer_s  timer;
  logic                 pin_in;
  logic                 out_pin;
  logic                 t1_rst;
  logic                 t2_clr;
  logic                 irq;
  logic                 t1_hold;
  logic [15:0]          t1_val;
  logic [7:0]           t2_per;
  int                   mismatches;
  int                   checks_done;
  int                   cycles;
  ccp_unit_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer), .unit_pin_in(pin_in),
    .unit_output_pin(out_pin), .timer_one_reset(t1_rst), .timer_two_clear(t2_clr), .irq(irq));
  ccp_partner u_partner (.pclk(pclk), .presetn(presetn), .t1_hold(t1_hold), .t1_val(t1_val),
    .t1_reset_req(t1_rst), .t2_period(t2_per), .t2_clear_req(t2_clr), .timer_out(timer));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // ==========
  // shared tasks
  // ==========
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // request held from setup until pready is seen high at the sampling edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx[5:0], 2'b00}, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, {24'h0, d}, rd, err);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(name, exp, rd);
  endtask
  task automatic edge_pin(input logic v);
    @(posedge pclk);
    pin_in <= v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      edge_pin(1'b1);
      edge_pin(1'b0);
    end
  endtask
  // ==========
  // scenarios
  // ==========
  task automatic t_reset();
    logic [31:0] rd;
    logic        err;
    rd_chk("control", IDX_CONTROL, 32'h0);
    rd_chk("status", IDX_STATUS, 32'h0);
    rd_chk("enable", IDX_IRQ_ENABLE, 32'h0);
    apb(1'b0, 8'h30, 32'h0, rd, err);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
  endtask
  task automatic t_capture(input logic [3:0] m, input int n, input logic [15:0] tv);
    t1_hold <= 1'b1;
    t1_val  <= tv;
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CONTROL, {4'h0, m});
    wr(IDX_IRQ_CLEAR, 8'h01);
    pulses(n - 1);
    rd_chk("early flag", IDX_STATUS, 32'h0);
    edge_pin(1'b1);
    rd_chk("rise flag", IDX_STATUS, {31'h0, m != MODE_CAP_FALL});
    edge_pin(1'b0);
    rd_chk("flag", IDX_STATUS, 32'h1);
    rd_chk("low", IDX_VALUE_LOW, {24'h0, tv[7:0]});
    rd_chk("high", IDX_VALUE_HIGH, {24'h0, tv[15:8]});
  endtask
  task automatic t_irq();
    wr(IDX_IRQ_ENABLE, 8'h01);
    repeat (2) @(negedge pclk);
    check("irq on", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_ENABLE, 8'h00);
    repeat (2) @(negedge pclk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_ENABLE, 8'h01);
    wr(IDX_IRQ_CLEAR, 8'h01);
    repeat (2) @(negedge pclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("status", IDX_STATUS, 32'h0);
  endtask
  task automatic t_switch();
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CONTROL, {4'h0, MODE_CAP_4});
    pulses(2);
    wr(IDX_CONTROL, {4'h0, MODE_CAP_16});
    wr(IDX_IRQ_CLEAR, 8'h01);
    pulses(13);
    rd_chk("kept count", IDX_STATUS, 32'h0);
    pulses(1);
    rd_chk("early capture", IDX_STATUS, 32'h1);
  endtask
  task automatic t_compare();
    logic [3:0] modes [5];
    logic       pins [5];
    modes = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR, MODE_CMP_SPEC, MODE_CMP_SET};
    pins  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      t1_hold <= 1'b1;
      t1_val  <= 16'h0100;
      wr(IDX_CONTROL, {4'h0, modes[i]});
      wr(IDX_VALUE_LOW, 8'h05);
      wr(IDX_VALUE_HIGH, 8'h01);
      wr(IDX_IRQ_CLEAR, 8'h01);
      t1_hold <= 1'b0;
      repeat (20) @(negedge pclk);
      check("match irq", 32'h1, {31'h0, irq});
      rd_chk("match flag", IDX_STATUS, 32'h1);
      @(negedge pclk);
      check("pin", {31'h0, pins[i]}, {31'h0, out_pin});
      if (modes[i] == MODE_CMP_SPEC) check("restart", 32'h1, {31'h0, timer.t1_count < 16'h0105});
    end
    wr(IDX_CONTROL, 8'h00);
    @(negedge pclk);
    check("pin off", 32'h0, {31'h0, out_pin});
  endtask
  task automatic measure(input string name, input int exp_hi);
    int hi;
    int clr;
    hi  = 0;
    clr = 0;
    repeat (40) @(negedge pclk);
    repeat (32) begin
      @(negedge pclk);
      hi  += int'(out_pin === 1'b1);
      clr += int'(t2_clr === 1'b1);
    end
    check(name, exp_hi, hi);
    check("period ends", 32'd2, clr);
  endtask
  task automatic t_pwm();
    int n;
    t2_per <= 8'h03;
    wr(IDX_VALUE_LOW, 8'h00);
    wr(IDX_CONTROL, 8'h0c);
    measure("zero duty", 0);
    wr(IDX_VALUE_LOW, 8'h01);
    wr(IDX_CONTROL, 8'h2c);
    measure("ten bit duty", 12);
    wr(IDX_VALUE_LOW, 8'h02);
    wr(IDX_CONTROL, 8'h0c);
    measure("byte duty", 16);
    wr(IDX_VALUE_HIGH, 8'h77);
    rd_chk("reloaded high", IDX_VALUE_HIGH, 32'h2);
    n = 0;
    while (out_pin !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    wr(IDX_CONTROL, 8'h00);
    @(negedge pclk);
    check("pwm off", 32'h0, {31'h0, out_pin});
  endtask
  // ==========
  // main sequence
  // ==========
  initial begin
    presetn     = 1'b0;
    req         = '0;
    pin_in      = 1'b0;
    t1_hold     = 1'b1;
    t1_val      = 16'h0000;
    t2_per      = 8'h03;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capture(MODE_CAP_FALL, 1, 16'h1234);
    t_capture(MODE_CAP_RISE, 1, 16'ha55a);
    t_irq();
    t_capture(MODE_CAP_4, 4, 16'h0f0e);
    t_capture(MODE_CAP_16, 16, 16'hc3e1);
    t_switch();
    t_compare();
    t_pwm();
    end_of_test();
  end
endmodule
